// *** slbs_map.svh ***
// Purpose: constants for the status LED and beeper sequencer
// Assumes: 100 MHz clock, times counted in millisecond ticks
// Notes: definitions only
`ifndef SLBS_MAP_SVH
`define SLBS_MAP_SVH
`define SLBS_CLK_HZ 100000000
`define SLBS_TICK_HZ 1000
`define SLBS_SHORT_BEEP_MS 500
`define SLBS_LONG_BEEP_MS 1000
`define SLBS_FLASH_MS 500
`define SLBS_POWER_DELAY_MS 3000
`define SLBS_SUSPEND_MS 10000
`define SLBS_STEP_MS 250
`define SLBS_GAP_MS 200
`define SLBS_BLINK_MS 125
`define SLBS_LED_ALL 4'hf
`define SLBS_LED_READY 4'h3
`define SLBS_LED_ONE 4'h1
`define SLBS_LED_OFF 4'h0
`endif

// *** slbs_pkg.sv ***
// Purpose: types for the status LED and beeper sequencer
// Assumes: nothing
// Notes: one-hot states
package slbs_pkg;
    typedef enum logic [10:0] {
        SLBS_OFF     = 11'h001,
        SLBS_WAIT    = 11'h002,
        SLBS_FLASH   = 11'h004,
        SLBS_USBHOLD = 11'h008,
        SLBS_IDLE    = 11'h010,
        SLBS_READY   = 11'h020,
        SLBS_CARD    = 11'h040,
        SLBS_SEQ     = 11'h080,
        SLBS_DONE    = 11'h100,
        SLBS_FAIL    = 11'h200,
        SLBS_TAMPER  = 11'h400
    } slbs_state_e;
    typedef enum logic [1:0] {
        SLBS_BEEP_NONE  = 2'h0,
        SLBS_BEEP_SHORT = 2'h1,
        SLBS_BEEP_LONG  = 2'h2,
        SLBS_BEEP_TWO   = 2'h3
    } slbs_beep_e;
endpackage

// *** slbs_beeper.sv ***
// Purpose: beeper driver with short, long and double short beeps
// Assumes: tick is a one-cycle millisecond enable
// Notes: a new request restarts the current pattern
`timescale 1ns/1ps
`include "slbs_map.svh"
module slbs_beeper
    import slbs_pkg::*;
(
    // Clock, reset and millisecond tick
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic tick,
    // Request
    input wire logic req,
    input wire slbs_beep_e kind,
    // Output
    output logic beep,
    output logic busy
);
    logic [13:0] cnt_ff;
    logic [1:0] phase_ff;
    logic beep_ff;

    assign beep = beep_ff;
    assign busy = (phase_ff != 2'h0);

    // Phase 3 first short beep, 2 gap, 1 final beep
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff <= 14'h0;
            phase_ff <= 2'h0;
            beep_ff <= 1'b0;
        end else if (req && kind != SLBS_BEEP_NONE) begin
            beep_ff <= 1'b1;
            phase_ff <= (kind == SLBS_BEEP_TWO) ? 2'h3 : 2'h1;
            cnt_ff <= (kind == SLBS_BEEP_LONG) ? 14'(`SLBS_LONG_BEEP_MS) :
                14'(`SLBS_SHORT_BEEP_MS);
        end else if (tick && phase_ff != 2'h0) begin
            if (cnt_ff > 14'h1) begin
                cnt_ff <= cnt_ff - 14'h1;
            end else if (phase_ff == 2'h3) begin
                phase_ff <= 2'h2;
                beep_ff <= 1'b0;
                cnt_ff <= 14'(`SLBS_GAP_MS);
            end else if (phase_ff == 2'h2) begin
                phase_ff <= 2'h1;
                beep_ff <= 1'b1;
                cnt_ff <= 14'(`SLBS_SHORT_BEEP_MS);
            end else begin
                phase_ff <= 2'h0;
                beep_ff <= 1'b0;
                cnt_ff <= 14'h0;
            end
        end
    end

    property p_beep_busy;
        @(posedge clock) disable iff (sys_rst) beep_ff |-> busy;
    endproperty
    a_beep_busy: assert property (p_beep_busy) else $error("beep without busy");
endmodule

// *** slbs_sequencer.sv ***
// Purpose: LED, barcode light and beeper sequencer of a card reader
// Assumes: event inputs are one-cycle pulses synchronous to clock
// Notes: all timing from a millisecond tick divider
`timescale 1ns/1ps
`include "slbs_map.svh"
module slbs_sequencer
    import slbs_pkg::*;
#(
    parameter int CLK_HZ = `SLBS_CLK_HZ,
    parameter int TICK_HZ = `SLBS_TICK_HZ,
    parameter int POWER_DELAY_MS = `SLBS_POWER_DELAY_MS,
    parameter int SUSPEND_MS = `SLBS_SUSPEND_MS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Power and host status levels
    input wire logic usb_power,
    input wire logic serial_power,
    input wire logic usb_host_attach,
    input wire logic usb_suspend,
    input wire logic host_connected,
    input wire logic barcode_reader_fitted,
    input wire logic barcode_reader_enabled,
    input wire logic event_notify_mode,
    input wire logic tamper,
    // Transaction event pulses
    input wire logic armed,
    input wire logic card_detect,
    input wire logic read_success,
    input wire logic read_fail,
    input wire logic txn_cancel,
    input wire logic txn_done,
    // Indicators
    output logic [3:0] led,
    output logic barcode_reader_light,
    output logic beeper
);
    localparam int TICK_DIV = (CLK_HZ / TICK_HZ < 1) ? 1 : CLK_HZ / TICK_HZ;

    slbs_state_e state_ff;
    slbs_state_e nxt_state;
    logic [16:0] div_ff;
    logic tick;
    logic [13:0] tmr_ff;
    logic [13:0] nxt_tmr;
    logic [1:0] step_ff;
    logic [6:0] blink_ff;
    logic blink_on_ff;
    logic [3:0] led_ff;
    logic bcl_ff;
    logic beep_req;
    slbs_beep_e beep_kind;
    logic powered;
    logic usb_pwr_only_ff;

    assign powered = usb_power | serial_power;
    assign tick = (div_ff == 17'(TICK_DIV - 1));

    // Millisecond tick divider
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            div_ff <= 17'h0;
        end else if (tick) begin
            div_ff <= 17'h0;
        end else begin
            div_ff <= div_ff + 17'h1;
        end
    end

    // Blink phase for the tamper pattern
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            blink_ff <= 7'h0;
            blink_on_ff <= 1'b0;
        end else if (tick) begin
            if (blink_ff == 7'(`SLBS_BLINK_MS - 1)) begin
                blink_ff <= 7'h0;
                blink_on_ff <= ~blink_on_ff;
            end else begin
                blink_ff <= blink_ff + 7'h1;
            end
        end
    end

    // Remember whether power came from USB alone, for suspend handling
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            usb_pwr_only_ff <= 1'b0;
        end else if (state_ff == SLBS_OFF) begin
            usb_pwr_only_ff <= usb_power & ~serial_power;
        end
    end

    // Main state machine and its timer
    always_comb begin
        nxt_state = state_ff;
        nxt_tmr = tmr_ff;
        beep_req = 1'b0;
        beep_kind = SLBS_BEEP_NONE;
        if (tick && tmr_ff != 14'h0) begin
            nxt_tmr = tmr_ff - 14'h1;
        end
        case (state_ff)
            SLBS_OFF: begin
                if (powered) begin
                    nxt_state = SLBS_WAIT;
                    nxt_tmr = 14'(POWER_DELAY_MS);
                end
            end
            SLBS_WAIT: begin
                if (usb_host_attach || (tick && tmr_ff == 14'h1)) begin
                    nxt_state = SLBS_FLASH;
                    nxt_tmr = 14'(`SLBS_FLASH_MS);
                    beep_req = 1'b1;
                    beep_kind = SLBS_BEEP_SHORT;
                end
            end
            SLBS_FLASH: begin
                if (tick && tmr_ff == 14'h1) begin
                    nxt_state = SLBS_USBHOLD;
                    nxt_tmr = 14'(SUSPEND_MS);
                end
            end
            SLBS_USBHOLD: begin
                // Only a suspended port dims the display
                if (!usb_suspend || !usb_pwr_only_ff) begin
                    nxt_state = SLBS_READY;
                end else if (tick && tmr_ff == 14'h1) begin
                    nxt_state = SLBS_IDLE;
                end
            end
            SLBS_IDLE: begin
                // Serial supply alone never wakes the display
                if (host_connected && !usb_suspend) begin
                    nxt_state = SLBS_READY;
                end
            end
            SLBS_READY: begin
                if (card_detect || armed) begin
                    nxt_state = SLBS_CARD;
                end
            end
            SLBS_CARD: begin
                if (read_success) begin
                    nxt_state = SLBS_SEQ;
                    nxt_tmr = 14'(`SLBS_STEP_MS);
                end else if (read_fail || txn_cancel) begin
                    nxt_state = SLBS_FAIL;
                    beep_req = 1'b1;
                    beep_kind = SLBS_BEEP_TWO;
                    nxt_tmr = 14'(2 * `SLBS_SHORT_BEEP_MS + `SLBS_GAP_MS);
                end
            end
            SLBS_SEQ: begin
                if (tick && tmr_ff == 14'h1) begin
                    nxt_tmr = 14'(`SLBS_STEP_MS);
                    if (step_ff == 2'h3) begin
                        nxt_state = SLBS_DONE;
                        nxt_tmr = 14'(`SLBS_LONG_BEEP_MS);
                        beep_req = 1'b1;
                        beep_kind = SLBS_BEEP_LONG;
                    end
                end
            end
            SLBS_DONE: begin
                if (txn_done || (tick && tmr_ff == 14'h1)) begin
                    nxt_state = SLBS_READY;
                end
            end
            SLBS_FAIL: begin
                if (tick && tmr_ff == 14'h1) begin
                    nxt_state = SLBS_READY;
                end
            end
            SLBS_TAMPER: begin
                if (!tamper) begin
                    nxt_state = SLBS_READY;
                end
            end
            default: nxt_state = SLBS_OFF;
        endcase
        if (!powered) begin
            nxt_state = SLBS_OFF;
            nxt_tmr = 14'h0;
        end else if (tamper && state_ff != SLBS_OFF && state_ff != SLBS_WAIT) begin
            nxt_state = SLBS_TAMPER;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= SLBS_OFF;
            tmr_ff <= 14'h0;
        end else begin
            state_ff <= nxt_state;
            tmr_ff <= nxt_tmr;
        end
    end

    // Step through LEDs one to four during success
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            step_ff <= 2'h0;
        end else if (state_ff != SLBS_SEQ) begin
            step_ff <= 2'h0;
        end else if (tick && tmr_ff == 14'h1 && step_ff != 2'h3) begin
            step_ff <= step_ff + 2'h1;
        end
    end

    // LED and barcode light patterns, registered
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            led_ff <= `SLBS_LED_OFF;
            bcl_ff <= 1'b0;
        end else begin
            bcl_ff <= powered & barcode_reader_fitted & barcode_reader_enabled;
            case (state_ff)
                SLBS_FLASH: led_ff <= `SLBS_LED_ALL;
                SLBS_USBHOLD: led_ff <= `SLBS_LED_READY;
                SLBS_READY: led_ff <= `SLBS_LED_READY;
                SLBS_CARD: led_ff <= `SLBS_LED_ONE;
                // Progress LEDs fill one to four, the same after card or armed starts, and lead into the result LED
                SLBS_SEQ: led_ff <= 4'((5'h2 << step_ff) - 5'h1);
                SLBS_DONE: led_ff <= `SLBS_LED_ALL;
                SLBS_FAIL: led_ff <= `SLBS_LED_ONE;
                SLBS_TAMPER: led_ff <= blink_on_ff ? `SLBS_LED_ALL : `SLBS_LED_OFF;
                default: led_ff <= `SLBS_LED_OFF;
            endcase
        end
    end

    assign led = led_ff;
    assign barcode_reader_light = bcl_ff;

    slbs_beeper u_beeper (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick(tick),
        .req(beep_req),
        .kind(beep_kind),
        .beep(beeper),
        .busy()
    );

    property p_dark_unpowered;
        @(posedge clock) disable iff (sys_rst) !powered ##1 !powered |=> led == 4'h0;
    endproperty
    a_dark_unpowered: assert property (p_dark_unpowered) else $error("lit without power");

    property p_power_wait;
        @(posedge clock) disable iff (sys_rst)
            state_ff == SLBS_OFF && powered |=> state_ff == SLBS_WAIT;
    endproperty
    a_power_wait: assert property (p_power_wait) else $error("no wait on power");

    property p_flash_all;
        @(posedge clock) disable iff (sys_rst)
            state_ff == SLBS_FLASH && powered && !tamper |=> led == 4'hf;
    endproperty
    a_flash_all: assert property (p_flash_all) else $error("flash not all LEDs");

    property p_ready_leds;
        @(posedge clock) disable iff (sys_rst) state_ff == SLBS_READY |=> led == 4'h3;
    endproperty
    a_ready_leds: assert property (p_ready_leds) else $error("ready pattern wrong");

    property p_card_led;
        @(posedge clock) disable iff (sys_rst) state_ff == SLBS_CARD |=> led == 4'h1;
    endproperty
    a_card_led: assert property (p_card_led) else $error("card pattern wrong");

    property p_fail_beep;
        @(posedge clock) disable iff (sys_rst)
            state_ff == SLBS_CARD && powered && !tamper && !read_success &&
            read_fail |=> state_ff == SLBS_FAIL && beeper;
    endproperty
    a_fail_beep: assert property (p_fail_beep) else $error("no beep on failure");

    property p_idle_stays;
        @(posedge clock) disable iff (sys_rst)
            state_ff == SLBS_IDLE && !host_connected && powered && !tamper |=>
            state_ff == SLBS_IDLE;
    endproperty
    a_idle_stays: assert property (p_idle_stays) else $error("idle left");

    property p_ready_stays;
        @(posedge clock) disable iff (sys_rst)
            state_ff == SLBS_READY && !card_detect && !armed && powered && !tamper |=>
            state_ff == SLBS_READY;
    endproperty
    a_ready_stays: assert property (p_ready_stays) else $error("ready left");

    property p_done_ready;
        @(posedge clock) disable iff (sys_rst)
            state_ff == SLBS_DONE && txn_done && powered && !tamper |=>
            state_ff == SLBS_READY;
    endproperty
    a_done_ready: assert property (p_done_ready) else $error("no return to ready");
endmodule

// *** slbs_host_model.sv ***
// Purpose: model of the transaction controller and host status beside the sequencer
// Assumes: the bench calls its tasks; levels and pulses change only after rising edges
// Notes: pulses last exactly one clock, as the sequencer samples them once
`timescale 1ns/1ps
module slbs_host_model (
    // Clock
    input wire logic clock,
    // Power and host levels
    output logic usb_power,
    output logic serial_power,
    output logic usb_suspend,
    output logic host_connected,
    output logic barcode_reader_fitted,
    output logic barcode_reader_enabled,
    output logic event_notify_mode,
    output logic tamper,
    // Transaction event pulses
    output logic usb_host_attach,
    output logic armed,
    output logic card_detect,
    output logic read_success,
    output logic read_fail,
    output logic txn_cancel,
    output logic txn_done
);
    logic [7:0] lv_ff = 8'h00;
    logic [6:0] pulse_ff = 7'h00;

    assign {usb_power, serial_power, usb_suspend, host_connected} = lv_ff[7:4];
    assign {barcode_reader_fitted, barcode_reader_enabled, event_notify_mode, tamper} = lv_ff[3:0];
    assign {usb_host_attach, armed, card_detect, read_success} = pulse_ff[6:3];
    assign {read_fail, txn_cancel, txn_done} = pulse_ff[2:0];

    task automatic set_lv(input int idx, input logic v);
        @(posedge clock);
        lv_ff[idx] <= v;
    endtask

    // Dropped after one clock so no event is seen twice
    task automatic pulse(input int idx);
        @(posedge clock);
        pulse_ff <= 7'h01 << idx;
        @(posedge clock);
        pulse_ff <= 7'h00;
    endtask
endmodule

// *** test_status_led_beeper_sequencer.sv ***
// Purpose: self-checking bench of the LED and beeper sequencer
// Assumes: tick shortened to 10 clocks, power delay 30 ticks, suspend 100 ticks
// Notes: durations allow a tick of phase slack plus a few cycles of latency
`timescale 1ns/1ps
module test_status_led_beeper_sequencer;
    localparam int TOL = 30;
    localparam int LIMIT = 90000;
    localparam int L_USB = 7, L_SER = 6, L_SUSP = 5, L_HOST = 4;
    localparam int L_FIT = 3, L_EN = 2, L_EVT = 1, L_TAMP = 0;
    localparam int P_ATT = 6, P_ARM = 5, P_CARD = 4, P_OK = 3, P_FAIL = 2, P_CANCEL = 1;
    localparam int P_DONE = 0;

    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic usb_power, serial_power, usb_host_attach, usb_suspend, host_connected;
    logic barcode_reader_fitted, barcode_reader_enabled, event_notify_mode, tamper;
    logic armed, card_detect, read_success, read_fail, txn_cancel, txn_done;
    logic [3:0] led;
    logic barcode_reader_light;
    logic beeper;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int n;

    always #5 clock = ~clock;

    slbs_host_model slbs_host_model_inst (
        .clock(clock), .usb_power(usb_power), .serial_power(serial_power),
        .usb_suspend(usb_suspend), .host_connected(host_connected),
        .barcode_reader_fitted(barcode_reader_fitted),
        .barcode_reader_enabled(barcode_reader_enabled),
        .event_notify_mode(event_notify_mode), .tamper(tamper),
        .usb_host_attach(usb_host_attach), .armed(armed), .card_detect(card_detect),
        .read_success(read_success), .read_fail(read_fail), .txn_cancel(txn_cancel),
        .txn_done(txn_done)
    );

    slbs_sequencer #(
        .TICK_HZ(10000000), .POWER_DELAY_MS(30), .SUSPEND_MS(100)
    ) slbs_sequencer_inst (
        .clock(clock), .sys_rst(sys_rst), .usb_power(usb_power),
        .serial_power(serial_power), .usb_host_attach(usb_host_attach),
        .usb_suspend(usb_suspend), .host_connected(host_connected),
        .barcode_reader_fitted(barcode_reader_fitted),
        .barcode_reader_enabled(barcode_reader_enabled),
        .event_notify_mode(event_notify_mode), .tamper(tamper), .armed(armed),
        .card_detect(card_detect), .read_success(read_success), .read_fail(read_fail),
        .txn_cancel(txn_cancel), .txn_done(txn_done), .led(led),
        .barcode_reader_light(barcode_reader_light), .beeper(beeper)
    );

    task automatic close_out;
        $display("Counts: %0d checks, %0d bad", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // A hung wait must still reach the verdict
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            bad_count++;
            close_out();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic chk_dur(input int k, input int e);
        check(((k > e - TOL) && (k < e + TOL)) ? e : k, e);
    endtask

    task automatic wait_led(input logic [3:0] v, input int max, output int k);
        k = 0;
        #1;
        while (led !== v && k < max) begin
            @(posedge clock);
            #1;
            k++;
        end
        check(led, v);
    endtask

    task automatic wait_beep(input logic v, input int max, output int k);
        k = 0;
        #1;
        while (beeper !== v && k < max) begin
            @(posedge clock);
            #1;
            k++;
        end
        check(beeper, v);
    endtask

    // Quiet hold: LEDs keep v and the beeper stays off for the whole span
    task automatic hold_still(input logic [3:0] v, input int span);
        int bad;
        bad = 0;
        repeat (span) begin
            @(posedge clock);
            #1;
            if (led !== v || beeper !== 1'b0) bad++;
        end
        check(bad, 0);
    endtask

    // Power-up: delay, short beep with all LEDs, then two LEDs
    task automatic power_up(input int lvl);
        slbs_host_model_inst.set_lv(lvl, 1'b1);
        wait_beep(1'b1, 1000, n);
        chk_dur(n, 305);
        wait_led(4'hf, 3, n);
        wait_beep(1'b0, 6000, n);
        chk_dur(n, 5000);
        wait_led(4'h3, 200, n);
    endtask

    task automatic t_dark;
        slbs_host_model_inst.set_lv(L_FIT, 1'b1);
        slbs_host_model_inst.set_lv(L_EN, 1'b1);
        hold_still(4'h0, 300);
        check(barcode_reader_light, 1'b0);
        $display("test dark done");
    endtask

    task automatic t_usb_on;
        slbs_host_model_inst.set_lv(L_HOST, 1'b1);
        power_up(L_USB);
        check(barcode_reader_light, 1'b1);
        slbs_host_model_inst.set_lv(L_SER, 1'b1);
        hold_still(4'h3, 500);
        slbs_host_model_inst.set_lv(L_SER, 1'b0);
        $display("test usb power done");
    endtask

    task automatic t_success;
        slbs_host_model_inst.pulse(P_CARD);
        wait_led(4'h1, 5, n);
        check(barcode_reader_light, 1'b1);
        slbs_host_model_inst.pulse(P_OK);
        wait_led(4'h3, 2600, n);
        chk_dur(n, 2500);
        wait_led(4'h7, 2600, n);
        chk_dur(n, 2500);
        wait_led(4'hf, 2600, n);
        chk_dur(n, 2500);
        wait_beep(1'b1, 2600, n);
        chk_dur(n, 2500);
        // Finish the transaction while the long beep still sounds
        slbs_host_model_inst.pulse(P_DONE);
        wait_led(4'h3, 5, n);
        wait_beep(1'b0, 11000, n);
        chk_dur(n, 10000);
        slbs_host_model_inst.set_lv(L_EN, 1'b0);
        repeat (3) @(posedge clock);
        #1;
        check(barcode_reader_light, 1'b0);
        slbs_host_model_inst.set_lv(L_EN, 1'b1);
        $display("test success done");
    endtask

    task automatic t_fail(input int start, input int ending);
        slbs_host_model_inst.pulse(start);
        wait_led(4'h1, 5, n);
        slbs_host_model_inst.pulse(ending);
        wait_beep(1'b1, 30, n);
        check(led, 4'h1);
        check(barcode_reader_light, 1'b1);
        wait_beep(1'b0, 6000, n);
        chk_dur(n, 5000);
        wait_beep(1'b1, 3000, n);
        chk_dur(n, 2000);
        wait_beep(1'b0, 6000, n);
        chk_dur(n, 5000);
        wait_led(4'h3, 6000, n);
        $display("test fail done");
    endtask

    task automatic t_tamper;
        slbs_host_model_inst.set_lv(L_TAMP, 1'b1);
        wait_led(4'hf, 1400, n);
        wait_led(4'h0, 1400, n);
        wait_led(4'hf, 1400, n);
        chk_dur(n, 1250);
        slbs_host_model_inst.set_lv(L_TAMP, 1'b0);
        wait_led(4'h3, 100, n);
        $display("test tamper done");
    endtask

    task automatic t_off;
        slbs_host_model_inst.set_lv(L_USB, 1'b0);
        slbs_host_model_inst.set_lv(L_SER, 1'b0);
        wait_led(4'h0, 5, n);
        check(barcode_reader_light, 1'b0);
        $display("test power off done");
    endtask

    // Attach on USB power alone with the port already suspended
    task automatic t_suspend;
        slbs_host_model_inst.set_lv(L_HOST, 1'b0);
        slbs_host_model_inst.set_lv(L_SUSP, 1'b1);
        slbs_host_model_inst.set_lv(L_USB, 1'b1);
        slbs_host_model_inst.pulse(P_ATT);
        wait_beep(1'b1, 40, n);
        wait_led(4'hf, 3, n);
        wait_beep(1'b0, 6000, n);
        chk_dur(n, 5000);
        wait_led(4'h3, 200, n);
        wait_led(4'h0, 1300, n);
        chk_dur(n, 1000);
        slbs_host_model_inst.set_lv(L_SER, 1'b1);
        hold_still(4'h0, 500);
        slbs_host_model_inst.set_lv(L_SUSP, 1'b0);
        slbs_host_model_inst.set_lv(L_HOST, 1'b1);
        wait_led(4'h3, 50, n);
        $display("test suspend done");
    endtask

    initial begin
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        t_dark();
        t_usb_on();
        t_success();
        t_fail(P_CARD, P_FAIL);
        slbs_host_model_inst.set_lv(L_EVT, 1'b1);
        t_fail(P_ARM, P_CANCEL);
        slbs_host_model_inst.set_lv(L_EVT, 1'b0);
        t_tamper();
        t_off();
        t_suspend();
        t_off();
        power_up(L_SER);
        $display("test serial power done");
        close_out();
    end
endmodule
